// [imprs_top.sv]
// interrupt mask and priority registers with two-level request arbitration
// assumes: sfr bus from the core is synchronous, reads answered one cycle later;
// base enable bits and the global gate come from the base enable register outside
`timescale 1ns/100ps
`include "imprs_consts.svh"

module imprs_top
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// sfr bus
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_bit_wr,
	input wire logic [2:0] sfr_bit_sel,
	input wire logic sfr_bit_val,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	// base enable register outside this block
	input wire logic global_irq_gate,
	input wire logic [6:0] core_src_gate,
	input wire logic [4:0] second_src_level,
	// source flags
	input wire logic [6:0] core_src_flag,
	input wire logic timer_three_low_overflow,
	input wire logic timer_three_high_overflow,
	input wire logic comparator_one_rise_flag,
	input wire logic comparator_one_fall_flag,
	input wire logic comparator_zero_rise_flag,
	input wire logic comparator_zero_fall_flag,
	input wire logic counter_array_flag,
	input wire logic conversion_done_flag,
	input wire logic window_compare_flag,
	input wire logic smbus_zero_flag,
	input wire logic timer_five_low_overflow,
	input wire logic timer_five_high_overflow,
	input wire logic timer_four_low_overflow,
	input wire logic timer_four_high_overflow,
	input wire logic smbus_one_flag,
	input wire logic uart_one_flag,
	input wire logic ext_level_input_two,
	// core sequencer
	input wire logic irq_ack,
	input wire logic irq_return,
	output logic irq_req,
	output logic irq_high,
	output logic [`IMPRS_NUM_SRCS-1:0] src_req,
	output imprs_pkg::imprs_svc_t svc_state
);

	// ==========================================
	// register state
	logic [6:0] core_priority_select_r;
	logic [7:0] extended_enable_one_r;
	logic [7:0] extended_enable_two_r;
	logic [7:0] extended_priority_one_r;
	logic [7:0] sfr_rdata_r;
	logic [`IMPRS_NUM_SRCS-1:0] src_req_r;
	imprs_pkg::imprs_svc_t svc_r;
	imprs_pkg::imprs_svc_t svc_nxt;

	logic sel_core;
	logic sel_en1;
	logic sel_en2;
	logic sel_pr1;
	assign sel_core = (sfr_addr == `IMPRS_CORE_PRIO_ADDR);
	assign sel_en1 = (sfr_addr == `IMPRS_EXT_EN_ONE_ADDR);
	assign sel_en2 = (sfr_addr == `IMPRS_EXT_EN_TWO_ADDR);
	assign sel_pr1 = (sfr_addr == `IMPRS_EXT_PRIO_ONE_ADDR);

	// ==========================================
	// core priority register
	// no page decode, bit and byte writes
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			core_priority_select_r <= 7'h00;
		else if (sel_core && sfr_wr)
			core_priority_select_r <= sfr_wdata[6:0];
		// bit 7 write has no effect
		else if (sel_core && sfr_bit_wr && sfr_bit_sel != 3'h7)
			core_priority_select_r[sfr_bit_sel] <= sfr_bit_val;
	end

	// ==========================================
	// extended registers, byte access only
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			extended_enable_one_r <= `IMPRS_EXT_ONE_RST;
		else if (sel_en1 && sfr_wr)
			extended_enable_one_r <= sfr_wdata & `IMPRS_EXT_ONE_MASK;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			extended_priority_one_r <= `IMPRS_EXT_ONE_RST;
		else if (sel_pr1 && sfr_wr)
			extended_priority_one_r <= sfr_wdata & `IMPRS_EXT_ONE_MASK;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			extended_enable_two_r <= `IMPRS_EXT_TWO_RST;
		// reserved bit 2 kept as written
		else if (sel_en2 && sfr_wr)
			extended_enable_two_r <= sfr_wdata & `IMPRS_EXT_TWO_MASK;
	end

	// ==========================================
	// read path, one cycle after the strobe
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			sfr_rdata_r <= 8'h00;
		else if (sfr_rd)
		begin
			if (sel_core)
				sfr_rdata_r <= `IMPRS_CORE_PRIO_FIXED | {1'b0, core_priority_select_r};
			else if (sel_en1)
				sfr_rdata_r <= extended_enable_one_r;
			else if (sel_en2)
				sfr_rdata_r <= extended_enable_two_r;
			else if (sel_pr1)
				sfr_rdata_r <= extended_priority_one_r;
			else
				sfr_rdata_r <= 8'h00;
		end
	end
	assign sfr_rdata = sfr_rdata_r;

	// ==========================================
	// source vectors, core sources in bits 6:0
	logic [`IMPRS_NUM_SRCS-1:0] flag_v;
	logic [`IMPRS_NUM_SRCS-1:0] gate_v;
	logic [`IMPRS_NUM_SRCS-1:0] level_v;
	logic [`IMPRS_NUM_SRCS-1:0] req_v;
	logic [`IMPRS_NUM_SRCS-1:0] req_high_v;
	logic [`IMPRS_NUM_SRCS-1:0] req_low_v;

	// level input two
	// bit 19 has no source and stays low
	assign flag_v = {
		1'b0,
		ext_level_input_two,
		uart_one_flag,
		smbus_one_flag,
		timer_four_low_overflow | timer_four_high_overflow,
		timer_five_low_overflow | timer_five_high_overflow,
		smbus_zero_flag,
		window_compare_flag,
		conversion_done_flag,
		counter_array_flag,
		comparator_zero_rise_flag | comparator_zero_fall_flag,
		comparator_one_rise_flag | comparator_one_fall_flag,
		timer_three_low_overflow | timer_three_high_overflow,
		core_src_flag
	};
	assign gate_v = {
		1'b0,
		extended_enable_two_r[`IMPRS_EXT_LEVEL_TWO_BIT],
		extended_enable_two_r[`IMPRS_UART_ONE_BIT],
		extended_enable_two_r[`IMPRS_SMBUS_ONE_BIT],
		extended_enable_two_r[`IMPRS_TIMER_FOUR_BIT],
		extended_enable_two_r[`IMPRS_TIMER_FIVE_BIT],
		extended_enable_one_r[`IMPRS_SMBUS_ZERO_BIT],
		extended_enable_one_r[`IMPRS_WINDOW_BIT],
		extended_enable_one_r[`IMPRS_CONV_DONE_BIT],
		extended_enable_one_r[`IMPRS_COUNTER_ARRAY_BIT],
		extended_enable_one_r[`IMPRS_CMP_ZERO_BIT],
		extended_enable_one_r[`IMPRS_CMP_ONE_BIT],
		extended_enable_one_r[`IMPRS_TIMER_THREE_BIT],
		core_src_gate
	};
	// core sources take their level here
	assign level_v = {
		1'b0,
		second_src_level,
		extended_priority_one_r[`IMPRS_SMBUS_ZERO_BIT],
		extended_priority_one_r[`IMPRS_WINDOW_BIT],
		extended_priority_one_r[`IMPRS_CONV_DONE_BIT],
		extended_priority_one_r[`IMPRS_COUNTER_ARRAY_BIT],
		extended_priority_one_r[`IMPRS_CMP_ZERO_BIT],
		extended_priority_one_r[`IMPRS_CMP_ONE_BIT],
		extended_priority_one_r[`IMPRS_TIMER_THREE_BIT],
		core_priority_select_r
	};

	imprs_src_gate #(.N(`IMPRS_NUM_SRCS)) u_gate
	(
		.flag(flag_v),
		.gate(gate_v),
		.level(level_v),
		.global_irq_gate(global_irq_gate),
		.req(req_v),
		.req_high(req_high_v),
		.req_low(req_low_v)
	);

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			src_req_r <= '0;
		else
			src_req_r <= req_v;
	end
	assign src_req = src_req_r;

	// ==========================================
	// nesting: high may interrupt low, never the reverse or equal
	logic any_high;
	logic any_low;
	logic take_high;
	logic take_low;
	assign any_high = |req_high_v;
	assign any_low = |req_low_v;
	assign take_high = any_high && (svc_r == imprs_pkg::SVC_IDLE || svc_r == imprs_pkg::SVC_LOW);
	assign take_low = any_low && !any_high && svc_r == imprs_pkg::SVC_IDLE;

	always_comb
	begin
		svc_nxt = svc_r;
		// return takes priority so an ack in the same cycle is not double counted
		if (irq_return)
		begin
			unique case (svc_r)
				imprs_pkg::SVC_IDLE: svc_nxt = imprs_pkg::SVC_IDLE;
				imprs_pkg::SVC_LOW: svc_nxt = imprs_pkg::SVC_IDLE;
				imprs_pkg::SVC_HIGH: svc_nxt = imprs_pkg::SVC_IDLE;
				imprs_pkg::SVC_HIGH_OVER_LOW: svc_nxt = imprs_pkg::SVC_LOW;
			endcase
		end
		else if (irq_ack && take_high)
			svc_nxt = (svc_r == imprs_pkg::SVC_LOW) ? imprs_pkg::SVC_HIGH_OVER_LOW : imprs_pkg::SVC_HIGH;
		else if (irq_ack && take_low)
			svc_nxt = imprs_pkg::SVC_LOW;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			svc_r <= imprs_pkg::SVC_IDLE;
		else
			svc_r <= svc_nxt;
	end

	assign irq_req = take_high | take_low;
	assign irq_high = take_high;
	assign svc_state = svc_r;

endmodule

// [imprs_consts.svh]
// offsets, field positions and reset values of the interrupt mask and priority registers
// assumes: included by the top module only
`ifndef IMPRS_CONSTS_SVH
`define IMPRS_CONSTS_SVH

// ==========================================
// register offsets on the sfr bus
`define IMPRS_CORE_PRIO_ADDR 8'h00_B8
`define IMPRS_EXT_EN_ONE_ADDR 8'h00_E6
`define IMPRS_EXT_EN_TWO_ADDR 8'h00_E7
`define IMPRS_EXT_PRIO_ONE_ADDR 8'h00_F6

// ==========================================
// reset values and stored-bit masks
`define IMPRS_CORE_PRIO_RST 8'h00_80
`define IMPRS_CORE_PRIO_FIXED 8'h00_80
`define IMPRS_CORE_PRIO_MASK 8'h00_7F
`define IMPRS_EXT_ONE_RST 8'h00_00
`define IMPRS_EXT_ONE_MASK 8'h00_FD
`define IMPRS_EXT_TWO_RST 8'h00_00
`define IMPRS_EXT_TWO_MASK 8'h00_3F

// ==========================================
// field positions
`define IMPRS_CORE_FIXED_BIT 7
`define IMPRS_TIMER_THREE_BIT 7
`define IMPRS_CMP_ONE_BIT 6
`define IMPRS_CMP_ZERO_BIT 5
`define IMPRS_COUNTER_ARRAY_BIT 4
`define IMPRS_CONV_DONE_BIT 3
`define IMPRS_WINDOW_BIT 2
`define IMPRS_EXT_ONE_RSVD_BIT 1
`define IMPRS_SMBUS_ZERO_BIT 0
`define IMPRS_TIMER_FIVE_BIT 5
`define IMPRS_TIMER_FOUR_BIT 4
`define IMPRS_SMBUS_ONE_BIT 3
`define IMPRS_UART_ONE_BIT 1
`define IMPRS_EXT_LEVEL_TWO_BIT 0

// ==========================================
// source counts
`define IMPRS_CORE_SRCS 7
`define IMPRS_NUM_SRCS 20

`endif

// [imprs_pkg.sv]
// types shared by the interrupt mask and priority block
// assumes: imprs_consts.svh holds the numbers
package imprs_pkg;

	// ==========================================
	// service nesting state
	typedef enum logic [1:0]
	{
		SVC_IDLE = 2'b00,
		SVC_LOW = 2'b01,
		SVC_HIGH = 2'b10,
		SVC_HIGH_OVER_LOW = 2'b11
	} imprs_svc_t;

endpackage

// [imprs_src_gate.sv]
// per-source request gating and level split
// assumes: flags, enables and levels are synchronous to ref_clk
`timescale 1ns/100ps
module imprs_src_gate
#(
	parameter int N = 20
)
(
	// source side
	input wire logic [N-1:0] flag,
	input wire logic [N-1:0] gate,
	input wire logic [N-1:0] level,
	input wire logic global_irq_gate,
	// gated requests
	output logic [N-1:0] req,
	output logic [N-1:0] req_high,
	output logic [N-1:0] req_low
);

	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_src
			assign req[i] = flag[i] & gate[i] & global_irq_gate;
			assign req_high[i] = req[i] & level[i];
			assign req_low[i] = req[i] & ~level[i];
		end
	endgenerate

endmodule

// [imprs_core_model.sv]
// core sequencer model: acks standing requests, returns on command
// assumes: irq_req is combinational from the block, mode and fin from the bench
`timescale 1ns/100ps
module imprs_core_model
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// bench control: 0 hold off, 1 prompt, 2 slow
	input wire logic [1:0] mode,
	input wire logic fin,
	// block side
	input wire logic irq_req,
	output logic irq_ack,
	output logic irq_return
);
logic [1:0] wait_r;
// ====
// slow mode lets the request stand four cycles
always_ff @(posedge ref_clk or negedge nrst)
	if (!nrst)
		wait_r <= 2'h0;
	else
		wait_r <= (irq_req && !irq_ack) ? wait_r + 2'h1 : 2'h0;
always_ff @(posedge ref_clk or negedge nrst)
	if (!nrst)
		irq_ack <= 1'b0;
	else
		irq_ack <= mode != 2'h0 && irq_req && !irq_ack && (mode == 2'h1 || wait_r == 2'h3);
always_ff @(posedge ref_clk or negedge nrst)
	if (!nrst)
		irq_return <= 1'b0;
	else
		irq_return <= fin;
endmodule

// [imprs_top_assertions.sv]
// port assertions for the mask and priority block
// assumes: bound to imprs_top, one clock domain
`timescale 1ns/100ps
module imprs_top_chk
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// read side
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	// requests and service
	input wire logic global_irq_gate,
	input wire logic timer_three_low_overflow,
	input wire logic timer_three_high_overflow,
	input wire logic irq_ack,
	input wire logic irq_return,
	input wire logic irq_req,
	input wire logic irq_high,
	input wire logic [19:0] src_req,
	input wire imprs_pkg::imprs_svc_t svc_state
);
default clocking @(posedge ref_clk); endclocking
default disable iff (!nrst);
// ====
// register reads and gating
core_fix_a: assert property (sfr_rd && sfr_addr == 8'hB8 |=> sfr_rdata[7] == 1'b1)
	else $error("core priority top bit low");
rsvd_one_a: assert property (sfr_rd && (sfr_addr == 8'hE6 || sfr_addr == 8'hF6) |=> !sfr_rdata[1])
	else $error("reserved bit one set");
two_top_a: assert property (sfr_rd && sfr_addr == 8'hE7 |=> sfr_rdata[7:6] == 2'h0)
	else $error("second enable top bits set");
gate_all_a: assert property (!global_irq_gate |-> !irq_req ##1 src_req == 20'h0_0000)
	else $error("request with global gate off");
t3_src_a: assert property (src_req[7] |-> $past(timer_three_low_overflow || timer_three_high_overflow))
	else $error("timer three request without flag");
// ====
// service nesting
high_busy_a: assert property (svc_state[1] |-> !irq_req)
	else $error("request during high service");
low_busy_a: assert property (svc_state == imprs_pkg::SVC_LOW && irq_req |-> irq_high)
	else $error("low request during low service");
ack_low_a: assert property (irq_ack && irq_req && !irq_high && !irq_return && svc_state == imprs_pkg::SVC_IDLE
	|=> svc_state == imprs_pkg::SVC_LOW) else $error("low ack missed");
ack_high_a: assert property (irq_ack && irq_req && irq_high && !irq_return && svc_state == imprs_pkg::SVC_IDLE
	|=> svc_state == imprs_pkg::SVC_HIGH) else $error("high ack missed");
ret_nest_a: assert property (irq_return && svc_state == imprs_pkg::SVC_HIGH_OVER_LOW
	|=> svc_state == imprs_pkg::SVC_LOW) else $error("nested return wrong");
cover property (svc_state == imprs_pkg::SVC_HIGH_OVER_LOW);
cover property (irq_req && irq_high);
cover property (sfr_rd && sfr_addr == 8'hB8);
endmodule
bind imprs_top imprs_top_chk u_chk (.ref_clk, .nrst, .sfr_addr, .sfr_rd, .sfr_rdata, .global_irq_gate,
	.timer_three_low_overflow, .timer_three_high_overflow, .irq_ack, .irq_return, .irq_req, .irq_high,
	.src_req, .svc_state);

// [testbench.sv]
// self-checking bench for the mask and priority block
// assumes: core sequencer model drives ack and return
`timescale 1ns/100ps
module testbench;
logic ref_clk, nrst, wr, bw, rd, glob, fin, bval, ack, ret, req, hi;
logic [7:0] adr, wd, rdat;
logic [2:0] bsel;
logic [6:0] cg;
logic [4:0] sl;
logic [23:0] rf;
logic [1:0] mode;
logic [19:0] sreq;
imprs_pkg::imprs_svc_t svc;
int miscompares = 0;
int num_checks = 0;
int cyc = 0;
imprs_top uut (.ref_clk, .nrst, .sfr_addr(adr), .sfr_wr(wr), .sfr_wdata(wd), .sfr_bit_wr(bw),
	.sfr_bit_sel(bsel), .sfr_bit_val(bval), .sfr_rd(rd), .sfr_rdata(rdat), .global_irq_gate(glob),
	.core_src_gate(cg), .second_src_level(sl), .core_src_flag(rf[6:0]), .timer_three_low_overflow(rf[7]),
	.timer_three_high_overflow(rf[8]), .comparator_one_rise_flag(rf[9]), .comparator_one_fall_flag(rf[10]),
	.comparator_zero_rise_flag(rf[11]), .comparator_zero_fall_flag(rf[12]), .counter_array_flag(rf[13]),
	.conversion_done_flag(rf[14]), .window_compare_flag(rf[15]), .smbus_zero_flag(rf[16]),
	.timer_five_low_overflow(rf[17]), .timer_five_high_overflow(rf[18]), .timer_four_low_overflow(rf[19]),
	.timer_four_high_overflow(rf[20]), .smbus_one_flag(rf[21]), .uart_one_flag(rf[22]),
	.ext_level_input_two(rf[23]), .irq_ack(ack), .irq_return(ret), .irq_req(req), .irq_high(hi),
	.src_req(sreq), .svc_state(svc));
imprs_core_model core (.ref_clk, .nrst, .mode, .fin, .irq_req(req), .irq_ack(ack), .irq_return(ret));
initial
begin
	ref_clk = 1'b0;
	forever #2.5 ref_clk = ~ref_clk;
end
// ====
// run limit, far above the several hundred cycles needed
always @(posedge ref_clk)
begin
	cyc++;
	if (cyc == 20000)
	begin
		miscompares++;
		close_out();
	end
end
task close_out();
	$display("checks %0d mismatches %0d", num_checks, miscompares);
	if (miscompares == 0 && num_checks > 0)
		$display("NO MISMATCHES");
	else
		$display("MISMATCHES SEEN");
	$finish;
endtask
task chk(string n, logic [19:0] s, logic [19:0] e);
	num_checks++;
	if (s !== e)
	begin
		miscompares++;
		$display("wrong value %s expected %h seen %h", n, e, s);
	end
endtask
// bit writes take index from d[2:0] and value from d[3]
task acc(logic [7:0] a, logic [7:0] d, logic w, logic b);
	@(posedge ref_clk);
	#1 {adr, wd, wr, bw, bsel, bval} = {a, d, w, b, d[2:0], d[3]};
	@(posedge ref_clk);
	#1 {wr, bw} = 2'h0;
endtask
task rd_chk(logic [7:0] a, logic [7:0] e);
	@(posedge ref_clk);
	#1 {adr, rd} = {a, 1'b1};
	@(posedge ref_clk);
	#1 rd = 1'b0;
	chk("read data", {12'h0, rdat}, {12'h0, e});
endtask
task wait_svc(imprs_pkg::imprs_svc_t e);
	int n;
	n = 0;
	while (svc !== e && n < 20)
	begin
		@(posedge ref_clk);
		#1 n++;
	end
	chk("service", {18'h0, svc}, {18'h0, e});
endtask
task ret_svc(imprs_pkg::imprs_svc_t e);
	@(posedge ref_clk);
	#1 fin = 1'b1;
	@(posedge ref_clk);
	#1 fin = 1'b0;
	wait_svc(e);
endtask
function int srcof(int j);
	if (j < 7) return j;
	if (j < 13) return 7 + (j - 7) / 2;
	if (j < 17) return j - 3;
	if (j < 21) return 14 + (j - 17) / 2;
	return j - 5;
endfunction
function logic [7:0] map1(logic [19:0] m);
	return {m[7], m[8], m[9], m[10], m[11], m[12], 1'b0, m[13]};
endfunction
task cfg(logic [19:0] g, logic [19:0] l);
	{cg, sl} = {g[6:0], l[18:14]};
	acc(8'hE6, map1(g), 1, 0);
	acc(8'hE7, {2'h0, g[14], g[15], g[16], 1'b0, g[17], g[18]}, 1, 0);
	acc(8'hB8, {1'b0, l[6:0]}, 1, 0);
	acc(8'hF6, map1(l), 1, 0);
endtask
// ====
// scenarios
task t_regs();
	rd_chk(8'hB8, 8'h80);
	rd_chk(8'hE6, 8'h00);
	rd_chk(8'hE7, 8'h00);
	rd_chk(8'h55, 8'h00);
	acc(8'hB8, 8'h00, 1, 0);
	rd_chk(8'hB8, 8'h80);
	acc(8'hB8, 8'hFF, 1, 0);
	rd_chk(8'hB8, 8'hFF);
	acc(8'hB8, 8'h03, 0, 1);
	rd_chk(8'hB8, 8'hF7);
	acc(8'hB8, 8'h07, 0, 1);
	rd_chk(8'hB8, 8'hF7);
	acc(8'hB8, 8'h0A, 1, 1);
	rd_chk(8'hB8, 8'h8A);
	acc(8'hE6, 8'h08, 0, 1);
	rd_chk(8'hE6, 8'h00);
	acc(8'hF6, 8'hFD, 1, 0);
	rd_chk(8'hF6, 8'hFD);
	acc(8'hE7, 8'hFB, 1, 0);
	rd_chk(8'hE7, 8'h3B);
endtask
// each flag alone, with only its own gate, then all but its own
task t_gate();
	logic [19:0] m;
	glob = 1'b1;
	for (int j = 0; j < 24; j++)
	begin
		m = 20'h1 << srcof(j);
		rf = 24'h1 << j;
		cfg(m, m);
		chk("request", {18'h0, req, hi}, 20'h3);
		chk("gated", sreq, m);
		cfg(m, ~m);
		chk("level", {19'h0, hi}, 20'h0);
		cfg(~m, ~m);
		chk("masked", sreq | {19'h0, req}, 20'h0);
	end
	rf = 24'hFF_FFFF;
	glob = 1'b0;
	@(posedge ref_clk);
	#1 chk("global off", sreq | {19'h0, req}, 20'h0);
	cfg(20'h7_FFFF, 20'h0);
	glob = 1'b1;
	@(posedge ref_clk);
	#1 chk("global on", sreq, 20'h7_FFFF);
	rf = 24'h0;
endtask
task t_nest();
	cfg(20'h7_FFFF, 20'h2);
	mode = 2'h2;
	rf = 24'h1;
	wait_svc(imprs_pkg::SVC_LOW);
	chk("same level", {19'h0, req}, 20'h0);
	mode = 2'h1;
	rf = 24'h3;
	wait_svc(imprs_pkg::SVC_HIGH_OVER_LOW);
	rf = 24'h0;
	ret_svc(imprs_pkg::SVC_LOW);
	ret_svc(imprs_pkg::SVC_IDLE);
	rf = 24'h2;
	wait_svc(imprs_pkg::SVC_HIGH);
	rf = 24'h3;
	chk("low in high", {19'h0, req}, 20'h0);
	rf = 24'h0;
	ret_svc(imprs_pkg::SVC_IDLE);
endtask
initial
begin
	nrst = 1'b0;
	{wr, bw, rd, glob, fin, bval} = 6'h0;
	{adr, wd, bsel, cg, sl, rf, mode} = '0;
	repeat (3) @(posedge ref_clk);
	#1 nrst = 1'b1;
	t_regs();
	t_gate();
	t_nest();
	close_out();
end
endmodule
